// ==== src/lpar_pkg.sv ====
// constants, types and states of the linear pixel array readout sequencer
// assumes a single 250 MHz system clock and a sensor clock pin sampled on it
// What this block does
// - a 128-stage token shift register, advanced by the sensor clock, sequences the pixels
// - a readout starts when scan start is high at a sensor clock rising edge
// - sample hold is raised from the rising edge of scan start
// - raising sample hold isolates all 128 samples; the capturing sensor clock edge starts integrator reset
// - each clock the token presents the next pixel on the analog output
// - integrators stay in reset for the first 18 clocks of a readout
// - new integration starts on clock 19 while pixel output continues
// - the 129th rising edge shifts the token out and floats the output
// - outside the pixel output phase the analog output floats
package lpar_pkg;

  localparam int unsigned NUM_PIXELS   = 128;
  localparam int unsigned SAMPLE_W     = 8;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [7:0]  RESET_CLOCKS = 8'h12;
  localparam logic [7:0]  LAST_PIXEL   = 8'h80;
  localparam logic [7:0]  COUNT_RESET  = 8'h00;
  localparam int unsigned CTD_US       = 20;
  localparam int unsigned MCLK_MHZ     = 250;
  localparam int unsigned CTD_CYCLES   = CTD_US * MCLK_MHZ;
  localparam int unsigned GAP_W        = 13;

  typedef struct packed {
    logic [6:0]          index;
    logic [SAMPLE_W-1:0] level;
  } lpar_pixel_s;

  typedef enum logic [1:0] {
    LPAR_IDLE  = 2'b00,
    LPAR_RESET = 2'b01,
    LPAR_INTEG = 2'b11
  } lpar_state_e;

endpackage : lpar_pkg

// ==== src/lpar_fifo.sv ====
// small flip-flop fifo carrying pixel samples toward the reader
// assumes a power-of-two depth so the pointers wrap on their own
`timescale 1ns/10ps
module lpar_fifo
  import lpar_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      fill   <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : lpar_fifo

// ==== src/lpar_readout.sv ====
// readout sequencer: start capture, sample hold, integrator reset, token shift
// assumes scan_start and sensor_clk are pins from another domain, sampled on mclk
`timescale 1ns/10ps
module lpar_readout
  import lpar_pkg::*;
#(
  parameter int unsigned CTD_LIMIT = CTD_CYCLES
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                scan_start,
  input  wire logic                sensor_clk,
  input  wire logic [SAMPLE_W-1:0] pixel_level,
  output logic [6:0]               pixel_select,
  output logic                     sample_hold,
  output logic                     integ_reset,
  output logic                     integ_run,
  output logic                     pixel_analog_out_en,
  output logic                     busy,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output lpar_pixel_s              out_pixel,
  output logic                     overrun,
  output logic                     start_early
);

  logic                  si_meta;
  logic                  si_sync;
  logic                  si_prev;
  logic                  ck_meta;
  logic                  ck_sync;
  logic                  ck_prev;
  logic [NUM_PIXELS-1:0] token;
  logic [7:0]            clk_count;
  lpar_state_e           state;
  lpar_state_e           next_state;
  logic                  push_pending;
  logic [GAP_W-1:0]      gap_count;
  logic                  fifo_ready;
  lpar_pixel_s           push_word;

  // both pins see the same two-stage delay, so their relative timing is kept
  always_ff @(posedge mclk) begin
    if (rst) begin
      si_meta <= 1'b0;
      si_sync <= 1'b0;
      si_prev <= 1'b0;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      si_meta <= scan_start;
      si_sync <= si_meta;
      si_prev <= si_sync;
      ck_meta <= sensor_clk;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
    end
  end

  wire ck_rise    = ck_sync & ~ck_prev;
  wire si_rise    = si_sync & ~si_prev;
  wire active     = state != LPAR_IDLE;
  wire capture    = ck_rise & si_sync & ~active;
  wire last_edge  = ck_rise & active & (clk_count == LAST_PIXEL);
  wire reset_done = ck_rise & (state == LPAR_RESET) & (clk_count == RESET_CLOCKS);
  wire gap_short  = gap_count < GAP_W'(CTD_LIMIT);

  always_comb begin
    next_state = state;
    case (state)
      LPAR_IDLE:  if (capture) next_state = LPAR_RESET;
      LPAR_RESET: if (reset_done) next_state = LPAR_INTEG;
      LPAR_INTEG: if (last_edge) next_state = LPAR_IDLE;
      default:    next_state = LPAR_IDLE;
    endcase
  end

  // token enters stage 0 on the capture edge and walks one stage per edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      token <= '0;
    end else if (ck_rise) begin
      token <= {token[NUM_PIXELS-2:0], capture};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state     <= LPAR_IDLE;
      clk_count <= COUNT_RESET;
    end else begin
      state <= next_state;
      if (capture) begin
        clk_count <= 8'h01;
      end else if (last_edge) begin
        clk_count <= COUNT_RESET;
      end else if (ck_rise && active) begin
        clk_count <= clk_count + 8'h01;
      end
    end
  end

  // hold goes up from the start edge itself and drops once the token leaves
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_hold <= 1'b0;
    end else if (si_rise && !active) begin
      sample_hold <= 1'b1;
    end else if (last_edge) begin
      sample_hold <= 1'b0;
    end
  end

  assign integ_reset         = state == LPAR_RESET;
  assign integ_run           = ~integ_reset;
  assign pixel_analog_out_en = |token;
  assign busy                = active;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pixel_select <= 7'h00;
    end else if (capture) begin
      pixel_select <= 7'h00;
    end else if (ck_rise && active && !last_edge) begin
      pixel_select <= pixel_select + 7'h01;
    end
  end

  // the level is taken one cycle after the index moves, so the front end has settled
  always_ff @(posedge mclk) begin
    if (rst) begin
      push_pending <= 1'b0;
    end else begin
      push_pending <= ck_rise & (capture | (active & ~last_edge));
    end
  end

  assign push_word = '{index: pixel_select, level: pixel_level};

  lpar_fifo #(
    .W     ($bits(lpar_pixel_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push_pending),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_pixel)
  );

  // the sensor clock cannot be stalled, so a full fifo loses the pixel and flags it
  always_ff @(posedge mclk) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (push_pending && !fifo_ready) begin
      overrun <= 1'b1;
    end else if (capture) begin
      overrun <= 1'b0;
    end
  end

  // warns of a start inside the charge transfer delay; the start is still taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_count   <= GAP_W'(CTD_LIMIT);
      start_early <= 1'b0;
    end else begin
      if (last_edge) begin
        gap_count <= '0;
      end else if (gap_short && !active) begin
        gap_count <= gap_count + 1'b1;
      end
      if (capture) begin
        start_early <= gap_short;
      end
    end
  end

  token_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(token) && (active || token == '0))
    else $error("token register holds more than one bit");

  start_capture_a: assert property (@(posedge mclk) disable iff (rst)
    capture |=> token[0] && clk_count == 8'h01 && integ_reset)
    else $error("start not captured on the sensor clock edge");

  hold_on_rise_a: assert property (@(posedge mclk) disable iff (rst)
    (si_rise && !active) |=> sample_hold)
    else $error("sample hold missing after scan start rise");

  hold_reset_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(integ_reset) |-> sample_hold)
    else $error("integrator reset began without sample hold");

  output_seq_a: assert property (@(posedge mclk) disable iff (rst)
    (ck_rise && active && !last_edge) |=> pixel_select == $past(pixel_select) + 7'h01)
    else $error("pixel index did not step with the clock");

  reset_len_a: assert property (@(posedge mclk) disable iff (rst)
    integ_reset |-> clk_count >= 8'h01 && clk_count <= RESET_CLOCKS)
    else $error("integrator reset outside clocks 1 to 18");

  integ_start_a: assert property (@(posedge mclk) disable iff (rst)
    reset_done |=> integ_run && pixel_analog_out_en && clk_count == RESET_CLOCKS + 8'h01)
    else $error("integration did not start on clock 19");

  end_edge_a: assert property (@(posedge mclk) disable iff (rst)
    last_edge |=> token == '0 && !pixel_analog_out_en && !sample_hold && !busy)
    else $error("token not cleared on the 129th edge");

  hiz_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !active |-> !pixel_analog_out_en)
    else $error("analog output driven outside the output phase");

  full_cycle_c: cover property (@(posedge mclk) disable iff (rst) last_edge);
  fifo_full_c: cover property (@(posedge mclk) disable iff (rst) !fifo_ready);
  early_start_c: cover property (@(posedge mclk) disable iff (rst) capture && gap_short);

endmodule : lpar_readout

// ==== test/lpar_ctrl_model.sv ====
// readout controller model: drives scan start and the sensor clock
// assumes the bench calls readout() from the mclk domain, clock idle low
`timescale 1ns/10ps
module lpar_ctrl_model (
  input  wire logic mclk,
  output logic      scan_start,
  output logic      sensor_clk
);
  initial begin
    scan_start = 1'b0;
    sensor_clk = 1'b0;
  end
  // 129 edges, each level held 6 mclk; redo raises a stray start before that edge
  // the start level for the next edge is set together with the clock fall, one write per step
  task automatic readout(input int redo);
    scan_start <= 1'b1;
    for (int k = 1; k <= 129; k++) begin
      repeat (6) @(negedge mclk);
      sensor_clk <= 1'b1;
      repeat (6) @(negedge mclk);
      scan_start <= (k + 1 == redo);
      sensor_clk <= 1'b0;
    end
  endtask : readout
endmodule : lpar_ctrl_model

// ==== test/tb_top.sv ====
// self-checking bench of the readout sequencer with a controller model
// assumes a pixel level that the bench derives from pixel_select
`timescale 1ns/10ps
module tb_top;
  import lpar_pkg::*;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                out_ready = 1'b1;
  logic                scan_start, sensor_clk, sample_hold, integ_reset, integ_run;
  logic                en, busy, out_valid, overrun, start_early;
  logic [6:0]          pixel_select;
  logic [SAMPLE_W-1:0] pixel_level;
  lpar_pixel_s         out_pixel;
  int n_errors = 0, check_count = 0, edge_k = 0, n_rst, n_run, n_en, n_hold;

  always #2 mclk = ~mclk;
  assign pixel_level = {1'b1, pixel_select} ^ 8'h5a;

  lpar_ctrl_model ctrl_i (.mclk(mclk), .scan_start(scan_start), .sensor_clk(sensor_clk));
  lpar_readout #(.CTD_LIMIT(50)) lpar_readout_i (
    .mclk(mclk), .rst(rst), .scan_start(scan_start), .sensor_clk(sensor_clk),
    .pixel_level(pixel_level), .pixel_select(pixel_select), .sample_hold(sample_hold),
    .integ_reset(integ_reset), .integ_run(integ_run), .pixel_analog_out_en(en),
    .busy(busy), .out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel),
    .overrun(overrun), .start_early(start_early));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // mid-level of each of the first 128 sensor clocks: the pixel shown and the control levels
  always @(posedge sensor_clk) edge_k++;
  always @(negedge sensor_clk) if (edge_k <= 128) begin
    check(pixel_select, 32'(edge_k - 1));
    n_rst += integ_reset;
    n_run += integ_run;
    n_en += en & busy;
    n_hold += sample_hold;
  end

  task automatic pop(input int idx);
    int w;
    w = 0;
    while (out_valid !== 1'b1 && w < 4000) begin
      @(negedge mclk);
      w++;
    end
    check(out_pixel, {7'(idx), {1'b1, 7'(idx)} ^ 8'h5a});
    @(negedge mclk);
  endtask : pop

  task automatic full_run(input int redo);
    edge_k = 0;
    n_rst = 0;
    n_run = 0;
    n_en = 0;
    n_hold = 0;
    fork
      ctrl_i.readout(redo);
      for (int i = 0; i < 128; i++) pop(i);
    join
    repeat (8) @(negedge mclk);
    check(n_rst, 18);
    check(n_run, 110);
    check(n_en, 128);
    check(n_hold, 128);
    check({en, busy, sample_hold, overrun, start_early}, 0);
  endtask : full_run

  // early start with the reader stalled: fifo fills and drops the rest
  task automatic fill_run();
    edge_k = 0;
    out_ready <= 1'b0;
    ctrl_i.readout(0);
    check({out_valid, overrun, start_early}, 3'b111);
    out_ready <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) pop(i);
    check(out_valid, 0);
  endtask : fill_run

  initial begin
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    repeat (60) @(negedge mclk);
    full_run(0);
    $display("test full readout done");
    fill_run();
    $display("test fifo overrun done");
    repeat (60) @(negedge mclk);
    full_run(40);
    $display("test ignored restart done");
    conclude();
  end

  initial begin
    #80000;
    n_errors++;
    conclude();
  end
endmodule : tb_top
